/* hdl/dsi_reply_map.svh */
// register offsets, packet codes and field positions of the reply framer
`ifndef DSI_REPLY_MAP_SVH
`define DSI_REPLY_MAP_SVH
`define A_CTRL      8'h00
`define A_LEN       8'h04
`define A_MAXRET    8'h08
`define A_STAT      8'h0C
`define A_ERRCNT    8'h10
`define A_DATA_HI   4'h2
`define RSP_OKAY    2'h0
`define RSP_DECERR  2'h3
`define VC_REPLY    2'h0
`define DT_ACK_ERR  6'h02
`define DT_CMD_LONG 6'h1C
`define DT_CMD_ONE  6'h21
`define DT_CMD_TWO  6'h22
`define DT_GEN_LONG 6'h1A
`define DT_GEN_ONE  6'h11
`define DT_GEN_TWO  6'h12
`define ERR_ECC1    8
`define ERR_ECCM    9
`define ERR_CSUM    10
`define ERR_PROTO   15
`define ERR_KEEP    16'h9FFF
`define CRC_INIT    16'hFFFF
`define CRC_POLY    16'h8408
`define ECC_P0      24'hF12CB7
`define ECC_P1      24'hF2555B
`define ECC_P2      24'h749A6D
`define ECC_P3      24'hB8E38E
`define ECC_P4      24'hDF03F0
`define ECC_P5      24'hEFFC00
`define RST_MAXRET  5'h10
`define CNT_MAX     8'hFF
`endif

/* hdl/dsi_reply_pkg.sv */
// types shared by the reply framer
package dsi_reply_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_PAY, TX_CRC} tx_state_t;
endpackage

/* hdl/dsi_response_and_error_report.sv */
// reply packet framer and receive error bookkeeping of the display link
`timescale 1ns/100ps
`include "dsi_reply_map.svh"
module dsi_response_and_error_report
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        link_clk,
  input  wire logic        bta_grant,
  input  wire logic        rx_pkt_done,
  input  wire logic [15:0] rx_err_flags,
  output logic             pkt_accept,
  output logic             lane_data,
  output logic             lane_active
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [7:0] hdr_ecc(input logic [23:0] h);
    return {2'h0, ^(h & `ECC_P5), ^(h & `ECC_P4), ^(h & `ECC_P3),
            ^(h & `ECC_P2), ^(h & `ECC_P1), ^(h & `ECC_P0)};
  endfunction

  dsi_reply_pkg::tx_state_t st_q, st_d;
  logic [7:0]  buf_q [16];
  logic [2:0]  ls_q;
  logic        lvl_q, aw_have_q, w_have_q, bta_pend_q, more_q;
  logic        armed_q, generic_q, long_q, sig_err_q, accept_q;
  logic        data_q, active_q;
  logic [7:0]  awaddr_q, cnt_q, cnt_d;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [4:0]  len_cfg_q, maxret_q, rem_q, off_q, len_q, idx_q;
  logic [2:0]  bit_q;
  logic [23:0] hdr_q;
  logic [15:0] last_err_q, crc_q;
  wire         ack_go;

  // ----------------------------------------------------------------
  // link clock sampling
  // ----------------------------------------------------------------
  // a change counts only once the second and third stage agree
  wire lagree = ls_q[1] == ls_q[2];
  wire lrise  = lagree & ls_q[2] & !lvl_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ls_q  <= 3'h0;
      lvl_q <= 1'b0;
    end
    else
    begin
      ls_q  <= {ls_q[1:0], link_clk};
      lvl_q <= lagree ? ls_q[2] : lvl_q;
    end
  end

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  wire wr_go  = aw_have_q & w_have_q & !bvalid;
  wire ar_hs  = arvalid & arready;
  wire wr_dat = awaddr_q[7:4] == `A_DATA_HI;
  wire wr_ok  = wr_dat | awaddr_q == `A_CTRL | awaddr_q == `A_LEN
              | awaddr_q == `A_MAXRET;
  wire wr_arm = wr_go & awaddr_q == `A_CTRL & wstrb_q[0] & wdata_q[0]
              & !armed_q;
  wire cnt_rd = ar_hs & araddr == `A_ERRCNT;
  wire rd_dat = araddr[7:4] == `A_DATA_HI;
  wire [3:0] rb = {araddr[3:2], 2'h0};
  wire rd_ok  = rd_dat | araddr == `A_CTRL | araddr == `A_LEN
              | araddr == `A_MAXRET | araddr == `A_STAT | araddr == `A_ERRCNT;
  wire [31:0] rd_mux =
      rd_dat ? {buf_q[rb + 4'h3], buf_q[rb + 4'h2], buf_q[rb + 4'h1], buf_q[rb]}
    : araddr == `A_CTRL ? {30'h0, generic_q, armed_q}
    : araddr == `A_LEN ? {27'h0, len_cfg_q}
    : araddr == `A_MAXRET ? {27'h0, maxret_q}
    : araddr == `A_STAT ? {last_err_q, 14'h0, st_q != dsi_reply_pkg::TX_IDLE,
                           sig_err_q}
    : araddr == `A_ERRCNT ? {24'h0, cnt_q} : 32'h0;

  assign awready = !aw_have_q & !bvalid;
  assign wready  = !w_have_q & !bvalid;
  assign arready = !rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `RSP_OKAY;
      rvalid    <= 1'b0;
      rresp     <= `RSP_OKAY;
      rdata     <= 32'h0;
    end
    else
    begin
      if (awvalid & awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= awaddr;
      end
      if (wvalid & wready)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end
      if (wr_go)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_ok ? `RSP_OKAY : `RSP_DECERR;
      end
      else if (bready)
        bvalid <= 1'b0;
      if (ar_hs)
      begin
        rvalid <= 1'b1;
        rdata  <= rd_mux;
        rresp  <= rd_ok ? `RSP_OKAY : `RSP_DECERR;
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  // payload store: one byte per strobe lane
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 16; i++)
        buf_q[i] <= 8'h0;
    end
    else if (wr_go & wr_dat)
    begin
      for (int k = 0; k < 4; k++)
        if (wstrb_q[k])
          buf_q[{awaddr_q[3:2], 2'(k)}] <= wdata_q[8*k +: 8];
    end
  end

  // ----------------------------------------------------------------
  // receive error bookkeeping
  // ----------------------------------------------------------------
  // reserved bit 13 and bit 14 are kept at zero; bit 15 passes through
  wire [15:0] flg     = rx_err_flags & `ERR_KEEP;
  wire        err_pkt = rx_pkt_done & (|flg);
  wire        cnt_hit = rx_pkt_done & (flg[`ERR_ECC1] | flg[`ERR_ECCM]
                      | flg[`ERR_CSUM]);

  // a packet that errs in the very cycle of the read is kept
  always_comb
  begin
    if (cnt_rd)
      cnt_d = cnt_hit ? 8'h01 : 8'h00;
    else if (cnt_hit & cnt_q != `CNT_MAX)
      cnt_d = cnt_q + 8'h01;
    else
      cnt_d = cnt_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q      <= 8'h0;
      sig_err_q  <= 1'b0;
      accept_q   <= 1'b0;
      last_err_q <= 16'h0;
    end
    else
    begin
      cnt_q     <= cnt_d;
      sig_err_q <= err_pkt | (sig_err_q & !cnt_rd);
      accept_q  <= rx_pkt_done & !(|flg);
      if (rx_pkt_done)
        last_err_q <= flg;
      else if (ack_go)
        last_err_q <= 16'h0;
    end
  end

  assign pkt_accept = accept_q;

  // ----------------------------------------------------------------
  // reply framing
  // ----------------------------------------------------------------
  // the host's size limit arrives through MAXRET; zero is taken as one
  wire [4:0] maxeff  = (maxret_q == 5'h0) ? 5'h1 : maxret_q;
  wire [4:0] chunk   = (rem_q > maxeff) ? maxeff : rem_q;
  wire       idle    = st_q == dsi_reply_pkg::TX_IDLE;
  wire       go      = idle & lrise & (bta_pend_q | more_q);
  assign ack_go = go & bta_pend_q & (|last_err_q);
  wire       rd_go   = go & !ack_go & armed_q;
  wire [5:0] dt_long = generic_q ? `DT_GEN_LONG : `DT_CMD_LONG;
  wire [5:0] dt_two  = generic_q ? `DT_GEN_TWO : `DT_CMD_TWO;
  wire [5:0] dt_one  = generic_q ? `DT_GEN_ONE : `DT_CMD_ONE;
  wire [5:0] rd_dt   = chunk > 5'h2 ? dt_long : chunk == 5'h2 ? dt_two : dt_one;
  wire [7:0] sd0     = buf_q[off_q[3:0]];
  wire [7:0] sd1     = chunk == 5'h2 ? buf_q[off_q[3:0] + 4'h1] : 8'h00;
  wire [15:0] rd_body = chunk > 5'h2 ? {8'h00, 3'h0, chunk} : {sd1, sd0};
  wire [4:0] pidx    = off_q + idx_q;
  wire [7:0] cur_byte =
      st_q == dsi_reply_pkg::TX_HDR ?
        (idx_q == 5'h3 ? hdr_ecc(hdr_q) : hdr_q[8*idx_q[1:0] +: 8])
    : st_q == dsi_reply_pkg::TX_PAY ? buf_q[pidx[3:0]]
    : idx_q == 5'h0 ? crc_q[7:0] : crc_q[15:8];
  wire step     = lrise & !idle;
  wire last_bit = step & bit_q == 3'h7;
  wire hdr_end  = st_q == dsi_reply_pkg::TX_HDR & idx_q == 5'h3;
  wire pay_end  = st_q == dsi_reply_pkg::TX_PAY & idx_q == len_q - 5'h1;
  wire crc_end  = st_q == dsi_reply_pkg::TX_CRC & idx_q == 5'h1;
  wire pkt_end  = last_bit & ((hdr_end & !long_q) | crc_end);
  wire foot_bit = crc_q[bit_q];

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      dsi_reply_pkg::TX_IDLE: if (ack_go | rd_go) st_d = dsi_reply_pkg::TX_HDR;
      dsi_reply_pkg::TX_HDR:
        if (last_bit & hdr_end)
          st_d = long_q ? dsi_reply_pkg::TX_PAY : dsi_reply_pkg::TX_IDLE;
      dsi_reply_pkg::TX_PAY: if (last_bit & pay_end) st_d = dsi_reply_pkg::TX_CRC;
      dsi_reply_pkg::TX_CRC: if (last_bit & crc_end) st_d = dsi_reply_pkg::TX_IDLE;
    endcase
  end

  // software setup: arm, size, and the host's return limit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      len_cfg_q <= 5'h1;
      maxret_q  <= `RST_MAXRET;
      generic_q <= 1'b0;
    end
    else if (wr_go & wstrb_q[0])
    begin
      if (awaddr_q == `A_LEN)
        len_cfg_q <= (wdata_q[4:0] > 5'h10) ? 5'h10 : wdata_q[4:0];
      if (awaddr_q == `A_MAXRET)
        maxret_q <= wdata_q[4:0];
      if (wr_arm)
        generic_q <= wdata_q[1];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q       <= dsi_reply_pkg::TX_IDLE;
      armed_q    <= 1'b0;
      bta_pend_q <= 1'b0;
      more_q     <= 1'b0;
      rem_q      <= 5'h0;
      off_q      <= 5'h0;
      len_q      <= 5'h0;
      long_q     <= 1'b0;
      hdr_q      <= 24'h0;
      idx_q      <= 5'h0;
      bit_q      <= 3'h0;
      crc_q      <= `CRC_INIT;
      data_q     <= 1'b0;
      active_q   <= 1'b0;
    end
    else
    begin
      st_q       <= st_d;
      bta_pend_q <= bta_grant | (bta_pend_q & !go);
      if (go)
        more_q <= 1'b0;
      if (wr_arm)
      begin
        armed_q <= 1'b1;
        rem_q   <= len_cfg_q;
        off_q   <= 5'h0;
      end
      if (ack_go)
      begin
        long_q <= 1'b0;
        hdr_q  <= {last_err_q, `VC_REPLY, `DT_ACK_ERR};
      end
      if (rd_go)
      begin
        len_q  <= chunk;
        long_q <= chunk > 5'h2;
        rem_q  <= rem_q - chunk;
        hdr_q  <= {rd_body, `VC_REPLY, rd_dt};
      end
      if (go)
      begin
        idx_q <= 5'h0;
        bit_q <= 3'h0;
        crc_q <= `CRC_INIT;
      end
      // data lane bits go out least significant first, one per rising link clock edge
      if (lrise)
        active_q <= !idle;
      if (step)
      begin
        data_q <= cur_byte[bit_q];
        bit_q  <= bit_q + 3'h1;
      end
      if (last_bit)
        idx_q <= (hdr_end | pay_end) ? 5'h0 : idx_q + 5'h1;
      if (last_bit & st_q == dsi_reply_pkg::TX_PAY)
        crc_q <= crc_byte(crc_q, cur_byte);
      // a finished reply chunk either hands over to the next or disarms
      if (pkt_end & hdr_q[5:0] != `DT_ACK_ERR)
      begin
        off_q <= off_q + len_q;
        if (rem_q == 5'h0)
          armed_q <= 1'b0;
        else
          more_q <= 1'b1;
      end
    end
  end

  assign lane_data   = data_q;
  assign lane_active = active_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_discard;
    @(posedge aclk) disable iff (!aresetn)
    rx_pkt_done && (|flg) |=> !pkt_accept;
  endproperty
  a_discard: assert property (p_discard) else $error("errored packet accepted");

  property p_accept;
    @(posedge aclk) disable iff (!aresetn)
    rx_pkt_done && !(|flg) |=> pkt_accept;
  endproperty
  a_accept: assert property (p_accept) else $error("clean packet not accepted");

  property p_last;
    @(posedge aclk) disable iff (!aresetn)
    rx_pkt_done |=> last_err_q == $past(flg) && last_err_q[14:13] == 2'h0;
  endproperty
  a_last: assert property (p_last) else $error("last error not kept");

  property p_sig;
    @(posedge aclk) disable iff (!aresetn)
    err_pkt |=> sig_err_q;
  endproperty
  a_sig: assert property (p_sig) else $error("signal mode bit not set");

  property p_cnt;
    @(posedge aclk) disable iff (!aresetn)
    cnt_hit && !cnt_rd && cnt_q != `CNT_MAX |=> cnt_q == $past(cnt_q) + 8'h01;
  endproperty
  a_cnt: assert property (p_cnt) else $error("error count missed");

  property p_clr;
    @(posedge aclk) disable iff (!aresetn)
    cnt_rd && !rx_pkt_done |=> cnt_q == 8'h00 && !sig_err_q;
  endproperty
  a_clr: assert property (p_clr) else $error("count not cleared");

  property p_ack;
    @(posedge aclk) disable iff (!aresetn)
    ack_go |=> hdr_q[5:0] == 6'h02 && hdr_q[23:8] == $past(last_err_q)
           && st_q == dsi_reply_pkg::TX_HDR;
  endproperty
  a_ack: assert property (p_ack) else $error("bad error reply header");

  property p_vc;
    @(posedge aclk) disable iff (!aresetn)
    !idle |-> hdr_q[7:6] == 2'h0;
  endproperty
  a_vc: assert property (p_vc) else $error("nonzero virtual channel");

  property p_long;
    @(posedge aclk) disable iff (!aresetn)
    st_q == dsi_reply_pkg::TX_PAY |-> long_q && hdr_q[15:8] == {3'h0, len_q}
      && (hdr_q[5:0] == 6'h1C || hdr_q[5:0] == 6'h1A) && len_q > 5'h2;
  endproperty
  a_long: assert property (p_long) else $error("bad long reply header");

  property p_split;
    @(posedge aclk) disable iff (!aresetn)
    rd_go |=> len_q <= maxeff && len_q != 5'h0;
  endproperty
  a_split: assert property (p_split) else $error("chunk exceeds limit");

  property p_foot;
    @(posedge aclk) disable iff (!aresetn)
    step && st_q == dsi_reply_pkg::TX_CRC && idx_q == 5'h0
      |=> lane_data == $past(foot_bit);
  endproperty
  a_foot: assert property (p_foot) else $error("footer order wrong");
endmodule // dsi_response_and_error_report

/* verif/dsi_host_model.sv */
// host side of the display link: receive events, turnaround and reply capture
`timescale 1ns/100ps
module dsi_host_model
(
  input  wire logic        aclk,
  input  wire logic        lane_data,
  input  wire logic        lane_active,
  output logic             link_clk,
  output logic             bta_grant,
  output logic             rx_pkt_done,
  output logic [15:0]      rx_err_flags
);
  logic [7:0] rx_q [$];
  logic       timed_out;

  initial
  begin
    link_clk     = 1'b0;
    bta_grant    = 1'b0;
    rx_pkt_done  = 1'b0;
    rx_err_flags = 16'h0000;
    timed_out    = 1'b0;
  end

  // ----------------------------------------------------------------
  // received packet event
  // ----------------------------------------------------------------
  task automatic send_pkt(input logic [15:0] f);
    @(posedge aclk);
    rx_pkt_done  <= 1'b1;
    rx_err_flags <= f;
    @(posedge aclk);
    rx_pkt_done  <= 1'b0;
    // released flags show the inverse so a stale value never looks valid
    rx_err_flags <= ~f;
  endtask

  // ----------------------------------------------------------------
  // turnaround, then clock the lane and collect bytes lsb first
  // ----------------------------------------------------------------
  task automatic turnaround();
    int         idle;
    int         bits;
    int         rises;
    logic [7:0] sh;
    logic       seen;
    rx_q.delete();
    idle  = 0;
    bits  = 0;
    rises = 0;
    seen  = 1'b0;
    sh    = 8'h00;
    @(posedge aclk);
    bta_grant <= 1'b1;
    @(posedge aclk);
    bta_grant <= 1'b0;
    // link clock runs only while the reply is being fetched
    #7;
    while (idle < 16 && rises < 3000)
    begin
      link_clk = 1'b1;
      rises++;
      if (lane_active === 1'b1)
      begin
        sh = {lane_data, sh[7:1]};
        bits++;
        seen = 1'b1;
        idle = 0;
        if (bits % 8 == 0)
          rx_q.push_back(sh);
      end
      else if (seen)
        idle++;
      #100;
      link_clk = 1'b0;
      #100;
    end
    timed_out = (rises >= 3000);
  endtask
endmodule // dsi_host_model

/* verif/dsi_response_and_error_report_tb.sv */
// self-checking bench of the reply framer and receive error bookkeeping
`timescale 1ns/100ps
`include "dsi_reply_map.svh"
module dsi_response_and_error_report_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, pkt_accept;
  logic [1:0]  bresp, rresp;
  logic        link_clk, bta_grant, rx_pkt_done, lane_data, lane_active;
  logic [15:0] rx_err_flags;
  logic [7:0]  exp_q [$];
  int          fail_count = 0;
  int          tests_run = 0;
  localparam logic [7:0]  pay [5] = '{8'h89, 8'h23, 8'h12, 8'hA2, 8'hE2};
  localparam logic [23:0] ecc_mask [6] = '{`ECC_P0, `ECC_P1, `ECC_P2, `ECC_P3, `ECC_P4, `ECC_P5};
  localparam int c_gen [8] = '{0, 0, 0, 1, 1, 1, 1, 0};
  localparam int c_len [8] = '{1, 2, 5, 1, 2, 5, 5, 5};
  localparam int c_max [8] = '{16, 16, 16, 16, 16, 16, 2, 3};

  dsi_response_and_error_report i_dsi_response_and_error_report
  (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .awaddr       (awaddr),
    .awvalid      (awvalid),
    .awready      (awready),
    .wdata        (wdata),
    .wstrb        (wstrb),
    .wvalid       (wvalid),
    .wready       (wready),
    .bresp        (bresp),
    .bvalid       (bvalid),
    .bready       (bready),
    .araddr       (araddr),
    .arvalid      (arvalid),
    .arready      (arready),
    .rdata        (rdata),
    .rresp        (rresp),
    .rvalid       (rvalid),
    .rready       (rready),
    .link_clk     (link_clk),
    .bta_grant    (bta_grant),
    .rx_pkt_done  (rx_pkt_done),
    .rx_err_flags (rx_err_flags),
    .pkt_accept   (pkt_accept),
    .lane_data    (lane_data),
    .lane_active  (lane_active)
  );

  dsi_host_model i_dsi_host_model
  (
    .aclk         (aclk),
    .lane_data    (lane_data),
    .lane_active  (lane_active),
    .link_clk     (link_clk),
    .bta_grant    (bta_grant),
    .rx_pkt_done  (rx_pkt_done),
    .rx_err_flags (rx_err_flags)
  );

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // comparison and closing report
  // ----------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  task automatic tmo(input string name);
    $display("[FAIL] %s expected answer seen none", name);
    fail_count++;
    results();
  endtask

  // ----------------------------------------------------------------
  // register bus master
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while ((awvalid || wvalid || bvalid !== 1'b1) && n < 100);
    if (n >= 100)
      tmo("write response");
    bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, bresp});
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                        input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while ((arvalid || rvalid !== 1'b1) && n < 100);
    if (n >= 100)
      tmo("read data");
    rready <= 1'b0;
    chk("rdata", exp, rdata & m);
    chk("rresp", {30'h0, r}, {30'h0, rresp});
  endtask

  // ----------------------------------------------------------------
  // expected reply packets
  // ----------------------------------------------------------------
  function automatic logic [7:0] ecc_of(input logic [23:0] h);
    logic [7:0] e;
    e = 8'h00;
    for (int i = 0; i < 6; i++)
      e[i] = ^(h & ecc_mask[i]);
    return e;
  endfunction

  function automatic logic [5:0] dt_of(input int gen, input int n);
    if (gen == 1)
      return (n > 2) ? `DT_GEN_LONG : (n == 2) ? `DT_GEN_TWO : `DT_GEN_ONE;
    return (n > 2) ? `DT_CMD_LONG : (n == 2) ? `DT_CMD_TWO : `DT_CMD_ONE;
  endfunction

  task automatic push_short(input logic [5:0] dt, input logic [7:0] d0, input logic [7:0] d1);
    exp_q.push_back({`VC_REPLY, dt});
    exp_q.push_back(d0);
    exp_q.push_back(d1);
    exp_q.push_back(ecc_of({d1, d0, `VC_REPLY, dt}));
  endtask

  task automatic push_long(input logic [5:0] dt, input int off, input int n);
    logic [15:0] c;
    c = `CRC_INIT;
    exp_q.push_back({`VC_REPLY, dt});
    exp_q.push_back(8'(n));
    exp_q.push_back(8'h00);
    exp_q.push_back(ecc_of({8'h00, 8'(n), `VC_REPLY, dt}));
    for (int k = 0; k < n; k++)
      exp_q.push_back(pay[off + k]);
    for (int k = 0; k < n * 8; k++)
      c = (c >> 1) ^ (((c[0] ^ pay[off + k / 8][k % 8]) == 1'b1) ? `CRC_POLY : 16'h0000);
    exp_q.push_back(c[7:0]);
    exp_q.push_back(c[15:8]);
  endtask

  task automatic cmp_reply(input string name);
    i_dsi_host_model.turnaround();
    if (i_dsi_host_model.timed_out === 1'b1)
      tmo(name);
    chk(name, 32'(exp_q.size()), 32'(i_dsi_host_model.rx_q.size()));
    for (int k = 0; k < exp_q.size() && k < i_dsi_host_model.rx_q.size(); k++)
      chk(name, {24'h0, exp_q[k]}, {24'h0, i_dsi_host_model.rx_q[k]});
    exp_q.delete();
  endtask

  task automatic rx_event(input logic [15:0] f, input logic acc);
    i_dsi_host_model.send_pkt(f);
    #1;
    chk("pkt_accept", {31'h0, acc}, {31'h0, pkt_accept});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int off;
    int rem;
    int n;
    aresetn = 1'b0;
    awaddr  = 8'h00;
    awvalid = 1'b0;
    wdata   = 32'h0000_0000;
    wstrb   = 4'h0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = 8'h00;
    arvalid = 1'b0;
    rready  = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`A_MAXRET, 32'h10, 32'h1F, `RSP_OKAY);
    axi_rd(`A_LEN, 32'h01, 32'h1F, `RSP_OKAY);
    axi_rd(`A_ERRCNT, 32'h00, 32'hFF, `RSP_OKAY);
    axi_rd(8'h40, 32'h00, 32'hFFFF_FFFF, `RSP_DECERR);
    axi_wr(8'h40, 32'h5A5A_5A5A, `RSP_DECERR);
    // error flags, counting and error reply
    rx_event(16'h0100, 1'b0);
    axi_rd(`A_STAT, 32'h0100_0001, 32'hFFFF_0001, `RSP_OKAY);
    rx_event(16'hE400, 1'b0);
    axi_rd(`A_STAT, 32'h8400_0001, 32'hFFFF_0001, `RSP_OKAY);
    axi_rd(`A_ERRCNT, 32'h02, 32'hFF, `RSP_OKAY);
    axi_rd(`A_STAT, 32'h00, 32'h01, `RSP_OKAY);
    push_short(`DT_ACK_ERR, 8'h00, 8'h84);
    cmp_reply("last error reply");
    rx_event(16'h8000, 1'b0);
    push_short(`DT_ACK_ERR, 8'h00, 8'h80);
    cmp_reply("protocol error reply");
    rx_event(16'h0100, 1'b0);
    push_short(`DT_ACK_ERR, 8'h00, 8'h01);
    cmp_reply("corrected ecc reply");
    axi_rd(`A_ERRCNT, 32'h01, 32'hFF, `RSP_OKAY);
    axi_rd(`A_ERRCNT, 32'h00, 32'hFF, `RSP_OKAY);
    axi_rd(`A_STAT, 32'h00, 32'h01, `RSP_OKAY);
    rx_event(16'h0000, 1'b1);
    // read replies of every kind, whole and split
    axi_wr(8'h20, 32'hA212_2389, `RSP_OKAY);
    axi_wr(8'h24, 32'h0000_00E2, `RSP_OKAY);
    for (int t = 0; t < 8; t++)
    begin
      axi_wr(`A_LEN, 32'(c_len[t]), `RSP_OKAY);
      axi_wr(`A_MAXRET, 32'(c_max[t]), `RSP_OKAY);
      axi_wr(`A_CTRL, {30'h0, c_gen[t] == 1, 1'b1}, `RSP_OKAY);
      axi_rd(`A_CTRL, {30'h0, c_gen[t] == 1, 1'b1}, 32'h3, `RSP_OKAY);
      off = 0;
      rem = c_len[t];
      while (rem > 0)
      begin
        n = (rem < c_max[t]) ? rem : c_max[t];
        if (n > 2)
          push_long(dt_of(c_gen[t], n), off, n);
        else
          push_short(dt_of(c_gen[t], n), pay[off], (n == 2) ? pay[off + 1] : 8'h00);
        off += n;
        rem -= n;
      end
      cmp_reply("read reply");
    end
    results();
  end
endmodule // dsi_response_and_error_report_tb
